// File: dgr_pkg.sv
// Shared offsets, field positions, reset values and timing for the gain guard
package dgr_pkg;
    localparam int          DGR_ADDR_W        = 8;
    localparam int          DGR_DATA_W        = 8;
    localparam int          DGR_SAMPLE_W      = 16;
    localparam int          DGR_GAIN_W        = 6;
    localparam int          DGR_LVL_W         = 7;
    localparam int          DGR_GAIN_FRAC     = 5;
    localparam int          DGR_STEP_CYCLES   = 4;
    localparam int          DGR_DIV_W         = 2;

    localparam logic [7:0]  DGR_OFF_QOFS_HI   = 8'h3E;
    localparam logic [7:0]  DGR_OFF_IGAIN     = 8'h3F;
    localparam logic [7:0]  DGR_OFF_QGAIN     = 8'h40;
    localparam logic [7:0]  DGR_OFF_RISE      = 8'h41;
    localparam logic [7:0]  DGR_OFF_FALL_SW   = 8'h42;
    localparam logic [7:0]  DGR_OFF_GATE      = 8'h43;
    localparam logic [7:0]  DGR_OFF_PROT      = 8'h44;

    localparam logic [7:0]  DGR_RST_QOFS_HI   = 8'h00;
    localparam logic [5:0]  DGR_RST_GAIN      = 6'h20;
    localparam logic [5:0]  DGR_RST_STEP      = 6'h01;
    localparam logic        DGR_RST_MAN_OFF   = 1'b0;
    localparam logic        DGR_RST_STATUS    = 1'b1;
    localparam logic [2:0]  DGR_RST_GATE      = 3'h7;
    localparam logic [7:0]  DGR_RST_PROT      = 8'h8D;

    localparam int          DGR_FS_MAN_OFF    = 7;
    localparam int          DGR_FS_STATUS     = 6;
    localparam int          DGR_FG_RAMP       = 2;
    localparam int          DGR_FG_SLEEP      = 1;
    localparam int          DGR_FG_PDOWN      = 0;
    localparam int          DGR_FP_MASTER     = 7;
    localparam int          DGR_FP_WARN       = 3;
    localparam int          DGR_FP_THRESH     = 2;
    localparam int          DGR_FP_ERR        = 0;
    localparam logic [7:0]  DGR_PROT_MASK     = 8'h8D;
endpackage : dgr_pkg

// File: dgr_ramp.sv
// Applied-gain ramp generator stepping once per tick
`timescale 1ns/100ps
`default_nettype none
module dgr_ramp
    import dgr_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // Control
    input  wire logic                 tick,
    input  wire logic                 go_on,
    input  wire logic                 ramp_en,
    input  wire logic [DGR_GAIN_W-1:0] target,
    input  wire logic [DGR_GAIN_W-1:0] rise_step,
    input  wire logic [DGR_GAIN_W-1:0] fall_step,
    // Applied gain, 2^-5 units
    output logic      [DGR_LVL_W-1:0] level
);
    logic [DGR_LVL_W-1:0] lvl_q;
    logic [DGR_LVL_W-1:0] lvl_d;
    logic [DGR_LVL_W-1:0] tgt;
    logic [DGR_LVL_W-1:0] rise2;
    logic [DGR_LVL_W-1:0] fall2;
    logic [DGR_LVL_W:0]   sum;

    // Step LSB is twice the gain LSB
    assign tgt   = {1'b0, target};
    assign rise2 = {rise_step, 1'b0};
    assign fall2 = {fall_step, 1'b0};
    assign sum   = {1'b0, lvl_q} + {1'b0, rise2};
    assign level = lvl_q;

    always_comb
    begin
        lvl_d = lvl_q;
        if (!go_on)
        begin
            if (!ramp_en)
                lvl_d = '0;
            else if (tick)
                lvl_d = (lvl_q > fall2) ? lvl_q - fall2 : '0;
        end
        else if (!ramp_en)
            lvl_d = tgt;
        else if (lvl_q > tgt)
            lvl_d = tgt;
        else if (tick && lvl_q < tgt)
            // Clamp so an uneven step never overshoots the setting
            lvl_d = (sum >= {1'b0, tgt}) ? tgt : sum[DGR_LVL_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            lvl_q <= '0;
        else
            lvl_q <= lvl_d;
    end
endmodule : dgr_ramp
`default_nettype wire

// File: dgr_guard.sv
// Gain, offset, ramp and output-guard logic with its register file
`timescale 1ns/100ps
`default_nettype none
module dgr_guard
    import dgr_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    srst,
    // Register port
    input  wire logic [DGR_ADDR_W-1:0]   reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic [DGR_DATA_W-1:0]   reg_wdata,
    output logic      [DGR_DATA_W-1:0]   reg_rdata,
    // Configuration from neighbouring blocks
    input  wire logic [7:0]              quad_offset_lower_byte,
    input  wire logic                    iq_gain_enable,
    // Events
    input  wire logic                    fifo_warning,
    input  wire logic                    power_over_threshold,
    // Pin
    input  wire logic                    transmit_gate_pin,
    // Sample stream
    input  wire logic [DGR_SAMPLE_W-1:0] i_sample,
    input  wire logic [DGR_SAMPLE_W-1:0] q_sample,
    output logic      [DGR_SAMPLE_W-1:0] i_out,
    output logic      [DGR_SAMPLE_W-1:0] q_out,
    // Power state
    output logic                         sleep_mode,
    output logic                         powerdown_mode,
    output logic                         output_off_status
);
    // Scale by gain in 2^-5 units, then saturate
    function automatic logic [DGR_SAMPLE_W-1:0] scale_sat(
        input logic [DGR_SAMPLE_W-1:0] smp,
        input logic [DGR_LVL_W-1:0]    g,
        input logic [DGR_SAMPLE_W-1:0] ofs
    );
        logic signed [24:0] prod;
        logic signed [24:0] acc;
        prod = 25'(signed'(smp)) * 25'(signed'({1'b0, g}));
        acc  = (prod >>> DGR_GAIN_FRAC) + 25'(signed'(ofs));
        if (acc > 25'sd32767)
            scale_sat = 16'h7FFF;
        else if (acc < -25'sd32768)
            scale_sat = 16'h8000;
        else
            scale_sat = acc[DGR_SAMPLE_W-1:0];
    endfunction : scale_sat

    // Registers
    logic [7:0] qofs_hi_q,  qofs_hi_d;
    logic [5:0] igain_q,    igain_d;
    logic [5:0] qgain_q,    qgain_d;
    logic [5:0] rise_q,     rise_d;
    logic [5:0] fall_q,     fall_d;
    logic       man_off_q,  man_off_d;
    logic [2:0] gate_q,     gate_d;
    logic [7:0] prot_q,     prot_d;
    logic       status_q,   status_d;
    logic       auto_off_q, auto_off_d;
    logic [7:0] rdata_q,    rdata_d;

    // Pin synchroniser and divider
    logic                 gate_s1_q, gate_s2_q, gate_prev_q;
    logic [DGR_DIV_W-1:0] div_q,     div_d;
    logic                 tick;

    // Datapath
    logic [15:0] i_q,     i_d;
    logic [15:0] q_q,     q_d;
    logic        sleep_q, sleep_d;
    logic        pdn_q,   pdn_d;

    logic                 wr_fall;
    logic                 gate_rise;
    logic                 trip;
    logic                 go_on;
    logic [DGR_LVL_W-1:0] level;
    logic [DGR_LVL_W-1:0] q_level;
    logic [15:0]          q_ofs;

    assign wr_fall   = reg_wr && reg_addr == DGR_OFF_FALL_SW;
    assign gate_rise = gate_s2_q && !gate_prev_q;
    assign tick      = div_q == DGR_DIV_W'(DGR_STEP_CYCLES - 1);

    // Automatic trips only under the master enable
    assign trip = prot_q[DGR_FP_MASTER] &&
        ((fifo_warning && prot_q[DGR_FP_WARN]) ||
         (fifo_warning && prot_q[DGR_FP_ERR]) ||
         (power_over_threshold && prot_q[DGR_FP_THRESH]));

    // Gate pin low holds output off only with ramp enabled
    assign go_on = !auto_off_q
        && !(iq_gain_enable && man_off_q)
        && !(gate_q[DGR_FG_RAMP] && !gate_s2_q);

    dgr_ramp u_ramp (
        .clk       (clk),
        .srst      (srst),
        .tick      (tick),
        .go_on     (go_on),
        .ramp_en   (gate_q[DGR_FG_RAMP]),
        .target    (igain_q),
        .rise_step (rise_q),
        .fall_step (fall_q),
        .level     (level)
    );

    // Q follows the ramp while below both gain settings, otherwise takes its own setting
    assign q_level = (level >= {1'b0, igain_q} || level > {1'b0, qgain_q})
                   ? {1'b0, qgain_q} : level;
    assign q_ofs   = {qofs_hi_q, quad_offset_lower_byte};

    always_comb
    begin
        qofs_hi_d = qofs_hi_q;
        igain_d   = igain_q;
        qgain_d   = qgain_q;
        rise_d    = rise_q;
        fall_d    = fall_q;
        man_off_d = man_off_q;
        gate_d    = gate_q;
        prot_d    = prot_q;
        if (reg_wr)
        begin
            case (reg_addr)
                DGR_OFF_QOFS_HI: qofs_hi_d = reg_wdata;
                DGR_OFF_IGAIN:   igain_d   = reg_wdata[5:0];
                DGR_OFF_QGAIN:   qgain_d   = reg_wdata[5:0];
                DGR_OFF_RISE:    rise_d    = reg_wdata[5:0];
                DGR_OFF_FALL_SW:
                begin
                    fall_d    = reg_wdata[5:0];
                    man_off_d = reg_wdata[DGR_FS_MAN_OFF];
                end
                DGR_OFF_GATE:    gate_d    = reg_wdata[2:0];
                DGR_OFF_PROT:    prot_d    = reg_wdata & DGR_PROT_MASK;
                default:         ;
            endcase
        end
        // Set beats clear; writing manual-on or gate rising releases it
        auto_off_d = auto_off_q;
        if ((wr_fall && !reg_wdata[DGR_FS_MAN_OFF]) || gate_rise)
            auto_off_d = 1'b0;
        if (trip)
            auto_off_d = 1'b1;
        // Status holds its last value while IQ gain is off
        status_d = status_q;
        if (iq_gain_enable)
            status_d = !go_on && level == '0;
        case (reg_addr)
            DGR_OFF_QOFS_HI: rdata_d = qofs_hi_q;
            DGR_OFF_IGAIN:   rdata_d = {2'b00, igain_q};
            DGR_OFF_QGAIN:   rdata_d = {2'b00, qgain_q};
            DGR_OFF_RISE:    rdata_d = {2'b00, rise_q};
            DGR_OFF_FALL_SW: rdata_d = {man_off_q, status_q, fall_q};
            DGR_OFF_GATE:    rdata_d = {5'b00000, gate_q};
            DGR_OFF_PROT:    rdata_d = prot_q;
            default:         rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            qofs_hi_q  <= DGR_RST_QOFS_HI;
            igain_q    <= DGR_RST_GAIN;
            qgain_q    <= DGR_RST_GAIN;
            rise_q     <= DGR_RST_STEP;
            fall_q     <= DGR_RST_STEP;
            man_off_q  <= DGR_RST_MAN_OFF;
            gate_q     <= DGR_RST_GATE;
            prot_q     <= DGR_RST_PROT;
            status_q   <= DGR_RST_STATUS;
            auto_off_q <= 1'b0;
            rdata_q    <= 8'h00;
        end
        else
        begin
            qofs_hi_q  <= qofs_hi_d;
            igain_q    <= igain_d;
            qgain_q    <= qgain_d;
            rise_q     <= rise_d;
            fall_q     <= fall_d;
            man_off_q  <= man_off_d;
            gate_q     <= gate_d;
            prot_q     <= prot_d;
            status_q   <= status_d;
            auto_off_q <= auto_off_d;
            rdata_q    <= rdata_d;
        end
    end

    // Free-running divider; step pace does not realign to the pin
    always_comb
    begin
        div_d   = div_q + 1'b1;
        sleep_d = gate_q[DGR_FG_SLEEP] && !gate_s2_q;
        pdn_d   = gate_q[DGR_FG_PDOWN] && !gate_s2_q;
        i_d     = scale_sat(i_sample, level, 16'h0000);
        q_d     = scale_sat(q_sample, q_level, q_ofs);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            gate_s1_q   <= 1'b0;
            gate_s2_q   <= 1'b0;
            gate_prev_q <= 1'b0;
            div_q       <= '0;
            sleep_q     <= 1'b0;
            pdn_q       <= 1'b0;
            i_q         <= 16'h0000;
            q_q         <= 16'h0000;
        end
        else
        begin
            gate_s1_q   <= transmit_gate_pin;
            gate_s2_q   <= gate_s1_q;
            gate_prev_q <= gate_s2_q;
            div_q       <= div_d;
            sleep_q     <= sleep_d;
            pdn_q       <= pdn_d;
            i_q         <= i_d;
            q_q         <= q_d;
        end
    end

    assign reg_rdata         = rdata_q;
    assign i_out             = i_q;
    assign q_out             = q_q;
    assign sleep_mode        = sleep_q;
    assign powerdown_mode    = pdn_q;
    assign output_off_status = status_q;
endmodule : dgr_guard
`default_nettype wire

// File: dgr_guard_props.sv
// Port-level checks for the gain guard
`timescale 1ns/100ps
`default_nettype none
module dgr_guard_props
    import dgr_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  srst,
    // Register port
    input wire logic [DGR_ADDR_W-1:0] reg_addr,
    input wire logic                  reg_wr,
    input wire logic [DGR_DATA_W-1:0] reg_wdata,
    input wire logic [DGR_DATA_W-1:0] reg_rdata,
    // Events and pin
    input wire logic                  iq_gain_enable,
    input wire logic                  fifo_warning,
    input wire logic                  power_over_threshold,
    input wire logic                  transmit_gate_pin,
    // Status
    input wire logic                  sleep_mode,
    input wire logic                  powerdown_mode,
    input wire logic                  output_off_status
);
    logic [7:0] prot_q, prot_d;
    logic [2:0] gate_q, gate_d;
    logic [2:0] cyc_q, cyc_d;
    // Shadows of the enables, since the checker cannot see inside
    always_comb
    begin
        prot_d = prot_q;
        gate_d = gate_q;
        cyc_d = (cyc_q == 3'h7) ? cyc_q : cyc_q + 3'h1;
        if (reg_wr && reg_addr == DGR_OFF_PROT)
            prot_d = reg_wdata & DGR_PROT_MASK;
        if (reg_wr && reg_addr == DGR_OFF_GATE)
            gate_d = reg_wdata[2:0];
    end
    always_ff @(posedge clk)
    begin
        prot_q <= srst ? DGR_RST_PROT : prot_d;
        gate_q <= srst ? DGR_RST_GATE : gate_d;
        cyc_q <= srst ? 3'h0 : cyc_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence wr_hi_s; reg_wr && reg_addr == DGR_OFF_QOFS_HI; endsequence
    sequence rd_hi_s; !reg_wr && reg_addr == DGR_OFF_QOFS_HI; endsequence
    offset_readback_a: assert property (
        wr_hi_s ##1 rd_hi_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("offset byte readback wrong");
    gain_upper_a: assert property (
        reg_addr == DGR_OFF_IGAIN |=> reg_rdata[7:6] == 2'b00)
        else $error("gain upper bits not zero");
    prot_read_a: assert property (
        reg_addr == DGR_OFF_PROT |=> reg_rdata == $past(prot_q))
        else $error("protection register readback wrong");
    gate_read_a: assert property (
        reg_addr == DGR_OFF_GATE |=> reg_rdata == {5'h00, $past(gate_q)})
        else $error("gate register readback wrong");
    status_hold_a: assert property (
        !iq_gain_enable [*4] |=> $stable(output_off_status))
        else $error("status moved while gain function off");
    sleep_cause_a: assert property (
        cyc_q > 3'h5 && sleep_mode |-> !$past(transmit_gate_pin, 3))
        else $error("sleep without low gate");
    sleep_on_a: assert property (
        cyc_q > 3'h5 && gate_q[1] && $past(gate_q[1])
        && !$past(transmit_gate_pin, 3) |-> sleep_mode)
        else $error("sleep missing");
    pdown_on_a: assert property (
        cyc_q > 3'h5 && gate_q[0] && $past(gate_q[0])
        && !$past(transmit_gate_pin, 3) |-> powerdown_mode)
        else $error("power-down missing");
    // Bounded by the slowest legal ramp-down from full gain
    warn_cut_a: assert property (
        iq_gain_enable && prot_q[7] && (prot_q[3] || prot_q[0])
        && fifo_warning |-> ##[1:300] output_off_status)
        else $error("warning did not shut output");
    thresh_cut_a: assert property (
        iq_gain_enable && prot_q[7] && prot_q[2]
        && power_over_threshold |-> ##[1:300] output_off_status)
        else $error("threshold did not shut output");
endmodule : dgr_guard_props
bind dgr_guard dgr_guard_props u_props (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .iq_gain_enable(iq_gain_enable),
    .fifo_warning(fifo_warning), .power_over_threshold(power_over_threshold),
    .transmit_gate_pin(transmit_gate_pin), .sleep_mode(sleep_mode),
    .powerdown_mode(powerdown_mode), .output_off_status(output_off_status));
`default_nettype wire

// File: dgr_gate_host.sv
// Host logic that drives the transmit gate pin after a lag
`timescale 1ns/100ps
`default_nettype none
module dgr_gate_host
#(
    parameter int LAG = 0
)
(
    // Clock
    input  wire logic clk,
    // Command
    input  wire logic want_on,
    // Pin
    output wire logic transmit_gate_pin
);
    logic [7:0] pipe_q = 8'h00;
    // Pin is asynchronous; moving it off the rising edge avoids races
    always @(negedge clk)
        pipe_q <= {pipe_q[6:0], want_on};
    assign transmit_gate_pin = pipe_q[LAG];
endmodule : dgr_gate_host
`default_nettype wire

// File: dgr_guard_tb.sv
// Self-checking bench for the gain guard
`timescale 1ns/100ps
`default_nettype none
module dgr_guard_tb
    import dgr_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        iq_en = 1'b1;
    logic        warn = 1'b0;
    logic        over = 1'b0;
    logic        want_on = 1'b0;
    logic        pin;
    logic [15:0] i_smp = 16'h1000;
    logic [15:0] i_out;
    logic [15:0] q_out;
    logic        sleep;
    logic        pdown;
    logic        off_st;
    int          err_total = 0;
    int          tests_run = 0;
    logic [7:0]  rst_tab [7] = '{8'h00, 8'h20, 8'h20, 8'h01, 8'h41, 8'h07,
                                 8'h8D};
    logic [10:0] cut_tab [7] = '{{8'h8D, 3'b101}, {8'h8D, 3'b011},
        {8'h0D, 3'b110}, {8'h88, 3'b101}, {8'h81, 3'b101},
        {8'h84, 3'b100}, {8'h89, 3'b010}};
    always #20 clk = ~clk;
    dgr_gate_host #(.LAG(3)) u_host (.clk(clk), .want_on(want_on),
        .transmit_gate_pin(pin));
    dgr_guard dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .quad_offset_lower_byte(8'h22), .iq_gain_enable(iq_en),
        .fifo_warning(warn), .power_over_threshold(over),
        .transmit_gate_pin(pin), .i_sample(i_smp), .q_sample(16'h1000),
        .i_out(i_out), .q_out(q_out), .sleep_mode(sleep),
        .powerdown_mode(pdown), .output_off_status(off_st));
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h got %h", nm, exp, got);
        end
    endtask : chk
    // Called at a falling edge; the write is taken at the next rise
    task automatic wr(input logic [7:0] a, d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, exp);
        reg_addr = a;
        @(negedge clk);
        chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask : rd
    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask : waitc
    initial
    begin
        waitc(10);
        srst = 1'b0;
        for (int k = 0; k < 7; k++)
            rd(8'h3E + 8'(k), rst_tab[k]);
        chk("output_off_status", 16'h0001, 16'(off_st));
        wr(8'h45, 8'hFF);
        rd(8'h45, 8'h00);
        wr(DGR_OFF_PROT, 8'hFF);
        rd(DGR_OFF_PROT, 8'h8D);
        wr(DGR_OFF_GATE, 8'hFF);
        rd(DGR_OFF_GATE, 8'h07);
        wr(DGR_OFF_FALL_SW, 8'h48);
        rd(DGR_OFF_FALL_SW, 8'h48);
        wr(DGR_OFF_QOFS_HI, 8'h01);
        rd(DGR_OFF_QOFS_HI, 8'h01);
        wr(DGR_OFF_IGAIN, 8'h70);
        rd(DGR_OFF_IGAIN, 8'h30);
        wr(DGR_OFF_QGAIN, 8'h10);
        wr(DGR_OFF_RISE, 8'h04);
        want_on = 1'b1;
        waitc(8);
        chk("i_out mid ramp", 16'h0001, 16'(i_out <= 16'h0800));
        waitc(60);
        chk("i_out", 16'h1800, i_out);
        chk("q_out", 16'h0922, q_out);
        rd(DGR_OFF_FALL_SW, 8'h08);
        i_smp = 16'h7000;
        waitc(2);
        chk("i_out sat", 16'h7FFF, i_out);
        i_smp = 16'h1000;
        wr(DGR_OFF_FALL_SW, 8'h88);
        waitc(40);
        chk("i_out", 16'h0000, i_out);
        rd(DGR_OFF_FALL_SW, 8'hC8);
        wr(DGR_OFF_FALL_SW, 8'h08);
        waitc(60);
        chk("i_out", 16'h1800, i_out);
        iq_en = 1'b0;
        wr(DGR_OFF_FALL_SW, 8'h88);
        waitc(40);
        chk("i_out", 16'h1800, i_out);
        chk("output_off_status", 16'h0000, 16'(off_st));
        wr(DGR_OFF_FALL_SW, 8'h08);
        iq_en = 1'b1;
        want_on = 1'b0;
        waitc(40);
        chk("sleep_mode", 16'h0001, 16'(sleep));
        chk("powerdown_mode", 16'h0001, 16'(pdown));
        chk("i_out", 16'h0000, i_out);
        want_on = 1'b1;
        waitc(60);
        chk("i_out", 16'h1800, i_out);
        wr(DGR_OFF_GATE, 8'h00);
        want_on = 1'b0;
        waitc(40);
        chk("sleep_mode", 16'h0000, 16'(sleep));
        chk("powerdown_mode", 16'h0000, 16'(pdown));
        chk("i_out", 16'h1800, i_out);
        wr(DGR_OFF_GATE, 8'h07);
        want_on = 1'b1;
        waitc(60);
        for (int k = 0; k < 7; k++)
        begin
            wr(DGR_OFF_PROT, cut_tab[k][10:3]);
            warn = cut_tab[k][2];
            over = cut_tab[k][1];
            waitc(1);
            warn = 1'b0;
            over = 1'b0;
            waitc(40);
            chk("cut status", 16'(cut_tab[k][0]), 16'(off_st));
            wr(DGR_OFF_FALL_SW, 8'h08);
            waitc(60);
            chk("i_out", 16'h1800, i_out);
        end
        close_out();
    end
    // Whole sequence needs under 2000 cycles
    initial
    begin
        repeat (6000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule : dgr_guard_tb
`default_nettype wire
